//--- design/tbx_exec.sv
// Execution unit for transfer, bit and flag operations behind an AHB-Lite slave
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module tbx_exec (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [tbx_pkg::PM_AW-1:0] pm_addr,
  output logic pm_rd,
  input wire logic [tbx_pkg::DATA_W-1:0] pm_rdata,
  output logic pm_wr,
  output logic [2*tbx_pkg::DATA_W-1:0] pm_wdata,
  output logic [tbx_pkg::SP_W-1:0] stk_addr,
  output logic stk_we,
  output logic [tbx_pkg::DATA_W-1:0] stk_wdata,
  output logic stk_rd,
  input wire logic [tbx_pkg::DATA_W-1:0] stk_rdata,
  output logic [tbx_pkg::IO_AW-1:0] io_addr,
  output logic io_rd,
  input wire logic [tbx_pkg::DATA_W-1:0] io_rdata,
  output logic io_we,
  output logic [tbx_pkg::DATA_W-1:0] io_wdata,
  input wire logic dbg_en,
  output logic sleep_req,
  output logic wdt_restart,
  output logic break_req
);
  import tbx_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic is_gpr(input logic [OFS_W-1:0] ofs);
    return (ofs & GPR_MASK) == OFS_GPR;
  endfunction

  function automatic logic [GPR_IW-1:0] gpr_idx(input logic [OFS_W-1:0] ofs);
    return ofs[GPR_IDX_LSB +: GPR_IW];
  endfunction

  function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_IW-1:0] b);
    logic [DATA_W-1:0] m;
    m = '0;
    m[b] = 1'b1;
    return m;
  endfunction

  // ==========================================================
  // State
  logic [DATA_W-1:0] gpr_r [GPR_N];
  logic [DATA_W-1:0] flags_r;
  logic [DATA_W-1:0] flags_nxt;
  logic [DATA_W-1:0] page_r;
  logic [SP_W-1:0] sp_r;
  tbx_state_t state_r;
  tbx_state_t state_nxt;
  tbx_op_t op_r;
  tbx_op_t go_op;
  logic [GPR_IW-1:0] sel_r;
  logic [BIT_IW-1:0] bit_r;
  logic [PM_AW-1:0] pm_addr_r;
  logic [SP_W-1:0] stk_addr_r;
  logic [IO_AW-1:0] io_addr_r;
  logic [DATA_W-1:0] io_wdata_r;
  logic [DATA_W-1:0] stk_wdata_r;
  logic [2*DATA_W-1:0] pm_wdata_r;
  logic ap_wr_r;
  logic ap_rd_r;
  logic [OFS_W-1:0] ap_ofs_r;

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  wire ap_take = hsel & htrans[1] & hready;
  wire busy = (state_r != ST_IDLE);
  // Register writes are dropped while an operation runs, so software polls busy first
  wire bus_wr = ap_wr_r & ~busy;
  wire cmd_go = bus_wr & (ap_ofs_r == OFS_CMD);
  wire wr_gpr = bus_wr & is_gpr(ap_ofs_r);
  wire wr_flags = bus_wr & (ap_ofs_r == OFS_FLAGS);
  wire wr_page = bus_wr & (ap_ofs_r == OFS_PAGE);
  wire wr_sp = bus_wr & (ap_ofs_r == OFS_SP);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ap_wr_r <= 1'b0;
      ap_rd_r <= 1'b0;
      ap_ofs_r <= '0;
    end
    else
    begin
      ap_wr_r <= ap_take & hwrite;
      ap_rd_r <= ap_take & ~hwrite;
      if (ap_take)
        ap_ofs_r <= haddr[OFS_W-1:0];
    end
  end

  wire [DATA_W-1:0] rd_gpr = gpr_r[gpr_idx(ap_ofs_r)];
  wire [31:0] rd_mux =
    is_gpr(ap_ofs_r) ? {24'h000000, rd_gpr} :
    (ap_ofs_r == OFS_CMD) ? {27'h0000000, op_r} :
    (ap_ofs_r == OFS_STAT) ? {31'h00000000, busy} :
    (ap_ofs_r == OFS_FLAGS) ? {24'h000000, flags_r} :
    (ap_ofs_r == OFS_PAGE) ? {24'h000000, page_r} :
    (ap_ofs_r == OFS_SP) ? {16'h0000, sp_r} : 32'h00000000;
  assign hrdata = ap_rd_r ? rd_mux : 32'h00000000;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================================
  // Command capture
  assign go_op = tbx_op_t'(hwdata[CMD_OP_LSB +: OP_W]);
  wire [GPR_IW-1:0] go_sel = hwdata[CMD_REG_LSB +: GPR_IW];
  wire [BIT_IW-1:0] go_bit = hwdata[CMD_BIT_LSB +: BIT_IW];
  wire [IO_AW-1:0] go_io = hwdata[CMD_IO_LSB +: IO_AW];
  wire [Z_W-1:0] z_cur = {gpr_r[R_ZHI], gpr_r[R_ZLO]};
  wire go_ext = (go_op == OP_XPML_R0) | (go_op == OP_XPML) | (go_op == OP_XPML_INC);
  wire [PM_AW-1:0] go_pm_addr = go_ext ? {page_r, z_cur} : {{(PM_AW-Z_W){1'b0}}, z_cur};

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      op_r <= OP_NOP;
      sel_r <= '0;
      bit_r <= '0;
      pm_addr_r <= '0;
      stk_addr_r <= '0;
      io_addr_r <= '0;
      stk_wdata_r <= '0;
      pm_wdata_r <= '0;
    end
    else if (cmd_go)
    begin
      op_r <= go_op;
      sel_r <= go_sel;
      bit_r <= go_bit;
      pm_addr_r <= go_pm_addr;
      stk_addr_r <= (go_op == OP_POP) ? sp_r + SP_STEP : sp_r;
      io_addr_r <= go_io;
      stk_wdata_r <= gpr_r[go_sel];
      pm_wdata_r <= {gpr_r[R_WHI], gpr_r[R_WLO]};
    end
  end

  // ==========================================================
  // Sequencer
  wire in_exec = (state_r == ST_EXEC);
  wire in_step2 = (state_r == ST_STEP2);
  wire in_take = (state_r == ST_PM_TAKE);
  wire is_pm_ld = (op_r == OP_PML_R0) | (op_r == OP_PML) | (op_r == OP_PML_INC) |
                  (op_r == OP_XPML_R0) | (op_r == OP_XPML) | (op_r == OP_XPML_INC);
  wire is_io_bit = (op_r == OP_IO_BSET) | (op_r == OP_IO_BCLR);
  wire is_two = (op_r == OP_PUSH) | (op_r == OP_POP) | is_io_bit;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: state_nxt = cmd_go ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_nxt = is_pm_ld ? ST_PM_WAIT : (is_two ? ST_STEP2 : ST_IDLE);
      ST_PM_WAIT: state_nxt = ST_PM_TAKE;
      ST_PM_TAKE: state_nxt = ST_IDLE;
      ST_STEP2: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // ==========================================================
  // Outside strobes
  assign pm_addr = pm_addr_r;
  assign pm_wdata = pm_wdata_r;
  assign stk_addr = stk_addr_r;
  assign stk_wdata = stk_wdata_r;
  assign io_addr = io_addr_r;
  assign io_wdata = io_wdata_r;
  assign pm_rd = in_exec & is_pm_ld;
  assign pm_wr = in_exec & (op_r == OP_PMS);
  assign stk_we = in_exec & (op_r == OP_PUSH);
  assign stk_rd = in_step2 & (op_r == OP_POP);
  assign io_rd = in_exec & ((op_r == OP_IN) | is_io_bit);
  assign io_we = (in_exec & (op_r == OP_OUT)) | (in_step2 & is_io_bit);
  assign sleep_req = in_exec & (op_r == OP_SLEEP);
  assign wdt_restart = in_exec & (op_r == OP_WDOG);
  assign break_req = in_exec & (op_r == OP_BREAK) & dbg_en;

  // Read-modify-write of one port bit; OUT data comes straight from the register
  wire [DATA_W-1:0] io_mask = bit_mask(bit_r);
  wire [DATA_W-1:0] io_bit_val = (op_r == OP_IO_BSET) ? (io_rdata | io_mask) :
                                                       (io_rdata & ~io_mask);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      io_wdata_r <= '0;
    else if (cmd_go)
      io_wdata_r <= gpr_r[go_sel];
    else if (in_exec & is_io_bit)
      io_wdata_r <= io_bit_val;
  end

  // ==========================================================
  // Rotate and flags
  logic [DATA_W-1:0] rot_res;
  logic rot_c;
  logic rot_z;
  logic rot_n;
  logic rot_v;
  wire [DATA_W-1:0] src_val = gpr_r[sel_r];

  tbx_rotate #(.W(DATA_W)) u_rot (
    .val(src_val),
    .cin(flags_r[FLG_C]),
    .left(op_r == OP_ROT_L),
    .res(rot_res),
    .c_out(rot_c),
    .z_out(rot_z),
    .n_out(rot_n),
    .v_out(rot_v)
  );

  tbx_flag_unit u_flag (
    .op(op_r),
    .bit_sel(bit_r),
    .flags_cur(flags_r),
    .src(src_val),
    .rot_c(rot_c),
    .rot_z(rot_z),
    .rot_n(rot_n),
    .rot_v(rot_v),
    .flags_nxt(flags_nxt)
  );

  // ==========================================================
  // Register file write-back
  wire is_rot = (op_r == OP_ROT_L) | (op_r == OP_ROT_R);
  wire to_r0 = (op_r == OP_PML_R0) | (op_r == OP_XPML_R0);
  wire [DATA_W-1:0] tload_val = (src_val & ~io_mask) | (flags_r[FLG_T] ? io_mask : '0);
  wire x_wen = in_take | (in_step2 & (op_r == OP_POP)) |
               (in_exec & ((op_r == OP_IN) | is_rot | (op_r == OP_T_LOAD)));
  wire [GPR_IW-1:0] x_idx = (in_take & to_r0) ? R_WLO : sel_r;
  wire [DATA_W-1:0] x_dat = in_take ? pm_rdata :
                            in_step2 ? stk_rdata :
                            (op_r == OP_IN) ? io_rdata :
                            is_rot ? rot_res : tload_val;
  // Increment lands in the same cycle as the byte and is written last, so Z as a destination is overwritten
  wire z_inc = in_take & ((op_r == OP_PML_INC) | (op_r == OP_XPML_INC));
  wire [PM_AW-1:0] pm_next = pm_addr_r + PM_STEP;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < GPR_N; i++)
        gpr_r[i] <= '0;
    end
    else
    begin
      if (wr_gpr)
        gpr_r[gpr_idx(ap_ofs_r)] <= hwdata[DATA_W-1:0];
      if (x_wen)
        gpr_r[x_idx] <= x_dat;
      if (z_inc)
      begin
        gpr_r[R_ZLO] <= pm_next[DATA_W-1:0];
        gpr_r[R_ZHI] <= pm_next[Z_W-1:DATA_W];
      end
    end
  end

  // ==========================================================
  // Page extension, stack pointer and status flags
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      page_r <= PAGE_RST;
      sp_r <= SP_RST;
      flags_r <= FLAGS_RST;
    end
    else
    begin
      if (wr_page)
        page_r <= hwdata[DATA_W-1:0];
      else if (z_inc & (op_r == OP_XPML_INC))
        page_r <= pm_next[PM_AW-1:Z_W];
      if (wr_sp)
        sp_r <= hwdata[SP_W-1:0];
      else if (in_exec & (op_r == OP_PUSH))
        sp_r <= sp_r - SP_STEP;
      else if (in_exec & (op_r == OP_POP))
        sp_r <= sp_r + SP_STEP;
      if (wr_flags)
        flags_r <= hwdata[DATA_W-1:0];
      else if (in_exec)
        flags_r <= flags_nxt;
    end
  end
endmodule

//--- include/tbx_pkg.sv
// Shared constants and types for the transfer, bit and flag execution unit
//
// Summary of operation
// - Post-increment program load reads byte at Z into register, bumps Z, 3 cycles.
// - Extended load addresses page extension above Z; no operand means R0; 3 cycles.
// - Extended post-increment bumps page extension and Z as one 24-bit value.
// - Push writes source register onto data stack in 2 cycles, flags kept.
// - Pop loads destination register from data stack in 2 cycles, flags kept.
// - I/O bit set or clear changes only bit b of port P in 2 cycles.
// - Rotate left through carry: old carry into bit 0, bit 7 to carry, ZCNV.
// - Rotate right through carry: old carry into bit 7, bit 0 to carry, ZCNV.
// - Bit store copies register bit b into transfer flag only, one cycle.
// - Bit load copies transfer flag into register bit b, one cycle, flags kept.
// - Single-cycle ops set or clear sign flag, or global interrupt enable.
// - Single-cycle ops set or clear overflow, carry, negative or zero alone.
// - Single-cycle ops set or clear half-carry or transfer flag alone.
// - Sleep issues in one cycle, flags kept, and requests power management.
// - Watchdog restart takes one cycle, flags kept, pulses the watchdog restart.
// - Break acts only with on-chip debug enabled; flags untouched.
package tbx_pkg;

  // ==========================================================
  // Widths
  localparam int DATA_W = 8;
  localparam int GPR_N = 32;
  localparam int GPR_IW = 5;
  localparam int BIT_IW = 3;
  localparam int IO_AW = 6;
  localparam int Z_W = 16;
  localparam int PM_AW = 24;
  localparam int SP_W = 16;
  localparam int OP_W = 5;
  localparam int OFS_W = 8;

  // ==========================================================
  // Register map (byte offsets, low address bits)
  localparam logic [OFS_W-1:0] OFS_CMD = 8'h00;
  localparam logic [OFS_W-1:0] OFS_STAT = 8'h04;
  localparam logic [OFS_W-1:0] OFS_FLAGS = 8'h08;
  localparam logic [OFS_W-1:0] OFS_PAGE = 8'h0c;
  localparam logic [OFS_W-1:0] OFS_SP = 8'h10;
  localparam logic [OFS_W-1:0] OFS_GPR = 8'h80;
  localparam logic [OFS_W-1:0] GPR_MASK = 8'h80;
  localparam int GPR_IDX_LSB = 2;

  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_REG_LSB = 8;
  localparam int CMD_BIT_LSB = 16;
  localparam int CMD_IO_LSB = 24;
  localparam int STAT_BUSY = 0;

  // ==========================================================
  // Reset values and address steps
  localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [DATA_W-1:0] PAGE_RST = 8'h00;
  localparam logic [SP_W-1:0] SP_RST = 16'h0fff;
  localparam logic [SP_W-1:0] SP_STEP = 16'h0001;
  localparam logic [PM_AW-1:0] PM_STEP = 24'h000001;

  // ==========================================================
  // Status flag positions and special registers
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  localparam logic [GPR_IW-1:0] R_WLO = 5'h00;
  localparam logic [GPR_IW-1:0] R_WHI = 5'h01;
  localparam logic [GPR_IW-1:0] R_ZLO = 5'h1e;
  localparam logic [GPR_IW-1:0] R_ZHI = 5'h1f;

  // ==========================================================
  // Operations, numbered in this order from zero
  typedef enum logic [OP_W-1:0] {
    OP_NOP,
    OP_PML_R0,
    OP_PML,
    OP_PML_INC,
    OP_XPML_R0,
    OP_XPML,
    OP_XPML_INC,
    OP_PMS,
    OP_IN,
    OP_OUT,
    OP_PUSH,
    OP_POP,
    OP_IO_BSET,
    OP_IO_BCLR,
    OP_ROT_L,
    OP_ROT_R,
    OP_T_STORE,
    OP_T_LOAD,
    OP_FLAG_SET,
    OP_FLAG_CLR,
    OP_SLEEP,
    OP_WDOG,
    OP_BREAK
  } tbx_op_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EXEC,
    ST_PM_WAIT,
    ST_PM_TAKE,
    ST_STEP2
  } tbx_state_t;

endpackage

//--- design/tbx_rotate.sv
// Rotate through carry with flag results
`timescale 1ns/10ps
module tbx_rotate #(
  parameter int W = tbx_pkg::DATA_W
) (
  input wire logic [W-1:0] val,
  input wire logic cin,
  input wire logic left,
  output logic [W-1:0] res,
  output logic c_out,
  output logic z_out,
  output logic n_out,
  output logic v_out
);
  import tbx_pkg::*;

  // ==========================================================
  // Datapath
  assign res = left ? {val[W-2:0], cin} : {cin, val[W-1:1]};
  assign c_out = left ? val[W-1] : val[0];
  assign z_out = (res == '0);
  assign n_out = res[W-1];
  assign v_out = n_out ^ c_out;
endmodule

//--- design/tbx_flag_unit.sv
// Next status flag value for the flag-touching operations
`timescale 1ns/10ps
module tbx_flag_unit (
  input wire tbx_pkg::tbx_op_t op,
  input wire logic [tbx_pkg::BIT_IW-1:0] bit_sel,
  input wire logic [tbx_pkg::DATA_W-1:0] flags_cur,
  input wire logic [tbx_pkg::DATA_W-1:0] src,
  input wire logic rot_c,
  input wire logic rot_z,
  input wire logic rot_n,
  input wire logic rot_v,
  output logic [tbx_pkg::DATA_W-1:0] flags_nxt
);
  import tbx_pkg::*;

  // ==========================================================
  // Flag update
  always_comb
  begin
    flags_nxt = flags_cur;
    unique case (op)
      OP_FLAG_SET: flags_nxt[bit_sel] = 1'b1;
      OP_FLAG_CLR: flags_nxt[bit_sel] = 1'b0;
      OP_T_STORE: flags_nxt[FLG_T] = src[bit_sel];
      OP_ROT_L, OP_ROT_R:
      begin
        // Sign and half-carry are left alone here
        flags_nxt[FLG_C] = rot_c;
        flags_nxt[FLG_Z] = rot_z;
        flags_nxt[FLG_N] = rot_n;
        flags_nxt[FLG_V] = rot_v;
      end
      default: flags_nxt = flags_cur;
    endcase
  end
endmodule

//--- verification/tbx_exec_props.sv
// Port-level assertions for the execution unit
`timescale 1ns/10ps
module tbx_exec_props import tbx_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [tbx_pkg::PM_AW-1:0] pm_addr,
  input wire logic pm_rd,
  input wire logic pm_wr,
  input wire logic stk_we,
  input wire logic stk_rd,
  input wire logic io_rd,
  input wire logic io_we,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic dbg_en,
  input wire logic sleep_req,
  input wire logic wdt_restart,
  input wire logic break_req
);
  // ==========================================================
  // Command tracking
  logic wcmd_r;
  logic [31:0] cmd_r;
  logic [4:0] op;
  logic [7:0] bmask;
  assign op = hwdata[4:0];
  assign bmask = 8'h01 << cmd_r[18:16];
  // Bench never writes a command while busy, so every command write starts an op
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wcmd_r <= 1'b0;
      cmd_r <= 32'h0;
    end
    else
    begin
      wcmd_r <= hsel && htrans[1] && hready && hwrite && (haddr[7:0] == OFS_CMD);
      if (wcmd_r)
      begin
        cmd_r <= hwdata;
      end
    end
  end
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // Checks
  AST_LOAD_STROBE: assert property (wcmd_r && op >= 5'd1 && op <= 5'd6 |=>
    pm_rd ##1 (!pm_rd) [*2]) else $error("load strobe timing wrong");
  AST_PLAIN_PAGE: assert property (wcmd_r && op >= 5'd1 && op <= 5'd3 |=>
    pm_rd && pm_addr[23:16] == 8'h00) else $error("plain load uses page");
  AST_PM_STORE: assert property (wcmd_r && op == 5'd7 |=>
    pm_wr && !pm_rd ##1 !pm_wr) else $error("program store strobe wrong");
  AST_PUSH: assert property (wcmd_r && op == 5'd10 |=>
    stk_we && !stk_rd ##1 !stk_we) else $error("push strobe wrong");
  AST_POP: assert property (wcmd_r && op == 5'd11 |=>
    !stk_we && !stk_rd ##1 stk_rd ##1 !stk_rd) else $error("pop strobe wrong");
  AST_IO_BIT: assert property (wcmd_r && (op == 5'd12 || op == 5'd13) |=>
    io_rd && !io_we ##1 io_we && io_wdata == (cmd_r[0] ? $past(io_rdata) & ~bmask :
    $past(io_rdata) | bmask)) else $error("io bit write wrong");
  AST_SLEEP: assert property (wcmd_r && op == 5'd20 |=>
    sleep_req ##1 !sleep_req) else $error("sleep request wrong");
  AST_WDR: assert property (wcmd_r && op == 5'd21 |=>
    wdt_restart ##1 !wdt_restart) else $error("watchdog restart wrong");
  AST_BREAK: assert property (wcmd_r && op == 5'd22 |=>
    break_req == dbg_en ##1 !break_req) else $error("break request wrong");
  cover property (wcmd_r && op == 5'd6);
  cover property (stk_rd);
  cover property (break_req);
endmodule

bind tbx_exec tbx_exec_props chk_i (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .pm_addr(pm_addr),
  .pm_rd(pm_rd), .pm_wr(pm_wr), .stk_we(stk_we), .stk_rd(stk_rd), .io_rd(io_rd), .io_we(io_we),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .dbg_en(dbg_en), .sleep_req(sleep_req),
  .wdt_restart(wdt_restart), .break_req(break_req));

//--- verification/tbx_mem_model.sv
// Behavioural program memory, data stack and I/O space
`timescale 1ns/10ps
module tbx_mem_model (
  input wire logic sys_clk,
  input wire logic [23:0] pm_addr,
  input wire logic pm_rd,
  output logic [7:0] pm_rdata,
  input wire logic [15:0] stk_addr,
  input wire logic stk_we,
  input wire logic [7:0] stk_wdata,
  input wire logic stk_rd,
  output logic [7:0] stk_rdata,
  input wire logic [5:0] io_addr,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  input wire logic io_we,
  input wire logic [7:0] io_wdata
);
  logic [7:0] stk [16];
  logic [7:0] io [64];
  logic [7:0] pd_r;
  logic [7:0] junk_r = 8'h69;
  logic [1:0] pv_r = 2'b00;
  // Outside a valid slot a toggling byte shows, so stale data cannot pass
  assign pm_rdata = pv_r[1] ? pd_r : junk_r;
  assign stk_rdata = stk_rd ? stk[stk_addr[3:0]] : junk_r;
  assign io_rdata = io_rd ? io[io_addr] : junk_r;
  always @(posedge sys_clk)
  begin
    junk_r <= ~junk_r;
    pv_r <= {pv_r[0], pm_rd};
    if (pm_rd)
      pd_r <= pm_addr[7:0] ^ pm_addr[15:8] ^ pm_addr[23:16] ^ 8'h5a;
    if (stk_we)
      stk[stk_addr[3:0]] <= stk_wdata;
    if (io_we)
      io[io_addr] <= io_wdata;
  end
endmodule

//--- verification/tbx_exec_tb.sv
// Self-checking bench for the execution unit
`timescale 1ns/10ps
module tbx_exec_tb;
  import tbx_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic dbg_en = 1'b0;
  logic hreadyout, hresp, pm_rd, pm_wr, stk_we, stk_rd, io_rd, io_we;
  logic sleep_req, wdt_restart, break_req;
  logic [31:0] hrdata;
  logic [23:0] pm_addr;
  logic [15:0] pm_wdata, stk_addr;
  logic [7:0] pm_rdata, stk_wdata, stk_rdata, io_rdata, io_wdata;
  logic [5:0] io_addr;
  int failures = 0;
  int compares = 0;
  tbx_exec uut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .pm_rdata(pm_rdata), .pm_wr(pm_wr), .pm_wdata(pm_wdata), .stk_addr(stk_addr),
    .stk_we(stk_we), .stk_wdata(stk_wdata), .stk_rd(stk_rd), .stk_rdata(stk_rdata),
    .io_addr(io_addr), .io_rd(io_rd), .io_rdata(io_rdata), .io_we(io_we),
    .io_wdata(io_wdata), .dbg_en(dbg_en), .sleep_req(sleep_req),
    .wdt_restart(wdt_restart), .break_req(break_req));
  tbx_mem_model mem_i (.sys_clk(sys_clk), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .pm_rdata(pm_rdata), .stk_addr(stk_addr), .stk_we(stk_we), .stk_wdata(stk_wdata),
    .stk_rd(stk_rd), .stk_rdata(stk_rdata), .io_addr(io_addr), .io_rd(io_rd),
    .io_rdata(io_rdata), .io_we(io_we), .io_wdata(io_wdata));
  // ==========================================================
  // Bus tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    compares++;
    if (q !== e || hresp !== 1'b0)
    begin
      failures++;
      $display("mismatch %0t addr %h got %h exp %h", $time, a, q, e);
    end
  endtask
  function automatic logic [7:0] ga(input int n);
    return OFS_GPR + 8'(n * 4);
  endfunction
  function automatic logic [31:0] pv(input logic [23:0] a);
    return {24'h0, a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a};
  endfunction
  // Each status read takes two cycles, so busy is seen in execution cycles 2, 4 and 6
  task automatic op(input int o, input int r, input int b, input int p, input int cyc);
    wr(OFS_CMD, (32'(o) << CMD_OP_LSB) | (32'(r) << CMD_REG_LSB) | (32'(b) << CMD_BIT_LSB)
      | (32'(p) << CMD_IO_LSB));
    for (int i = 1; i <= 3; i++)
      chk(OFS_STAT, {31'h0, (2 * i - 1) < cyc});
  endtask
  task automatic end_sim;
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // Stimulus
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    end_sim;
  end
  initial
  begin
    logic [7:0] v, r;
    logic c, co;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    chk(OFS_FLAGS, 32'(FLAGS_RST));
    chk(OFS_SP, 32'(SP_RST));
    wr(8'h20, 32'hffffffff);
    chk(8'h20, 32'h0);
    wr(OFS_FLAGS, 32'h5a);
    wr(OFS_PAGE, 32'h07);
    wr(ga(30), 32'hff);
    wr(ga(31), 32'h12);
    op(1, 0, 0, 0, 3);
    chk(ga(0), pv(24'h0012ff));
    op(2, 4, 0, 0, 3);
    chk(ga(4), pv(24'h0012ff));
    op(3, 5, 0, 0, 3);
    chk(ga(5), pv(24'h0012ff));
    chk(ga(30), 32'h00);
    chk(ga(31), 32'h13);
    chk(OFS_PAGE, 32'h07);
    // Write landing while a load is still busy must be dropped
    wr(OFS_CMD, 32'h1);
    wr(OFS_FLAGS, 32'hff);
    chk(OFS_STAT, 32'h0);
    chk(OFS_FLAGS, 32'h5a);
    wr(ga(30), 32'hff);
    wr(ga(31), 32'hff);
    op(6, 9, 0, 0, 3);
    chk(ga(9), pv(24'h07ffff));
    chk(ga(31), 32'h00);
    chk(OFS_PAGE, 32'h08);
    op(4, 0, 0, 0, 3);
    chk(ga(0), pv(24'h080000));
    op(5, 11, 0, 0, 3);
    chk(ga(11), pv(24'h080000));
    wr(ga(0), 32'ha5);
    wr(ga(1), 32'h3c);
    wr(ga(30), 32'h34);
    wr(ga(31), 32'h12);
    op(7, 0, 0, 0, 1);
    compares++;
    if ({pm_addr, pm_wdata} !== 40'h0012343ca5)
    begin
      failures++;
      $display("mismatch %0t program store address or data", $time);
    end
    wr(ga(12), 32'h3c);
    wr(ga(13), 32'hc3);
    op(10, 12, 0, 0, 2);
    op(10, 13, 0, 0, 2);
    chk(OFS_SP, 32'(SP_RST - 16'h0002));
    op(11, 14, 0, 0, 2);
    op(11, 15, 0, 0, 2);
    chk(ga(14), 32'hc3);
    chk(ga(15), 32'h3c);
    chk(OFS_SP, 32'(SP_RST));
    wr(ga(16), 32'h81);
    op(9, 16, 0, 42, 1);
    for (int b = 0; b < 8; b++)
      op(12 + b % 2, 0, b, 42, 2);
    op(8, 17, 0, 42, 1);
    chk(ga(17), 32'h55);
    chk(OFS_FLAGS, 32'h5a);
    for (int i = 0; i < 8; i++)
    begin
      v = i[2] ? (i[1] ? 8'hb6 : 8'h01) : (i[1] ? 8'h01 : 8'h80);
      c = i[1] ^ i[2];
      r = i[0] ? {c, v[7:1]} : {v[6:0], c};
      co = i[0] ? v[0] : v[7];
      wr(OFS_FLAGS, {24'h0, 7'h38, c});
      wr(ga(18), {24'h0, v});
      op(14 + i % 2, 18, 0, 0, 1);
      chk(ga(18), {24'h0, r});
      chk(OFS_FLAGS, {24'h0, 4'h7, r[7] ^ co, r[7], r == 8'h0, co});
    end
    wr(OFS_FLAGS, 32'h0);
    wr(ga(19), 32'h04);
    op(16, 19, 2, 0, 1);
    chk(OFS_FLAGS, 32'h40);
    op(17, 20, 7, 0, 1);
    chk(ga(20), 32'h80);
    chk(OFS_FLAGS, 32'h40);
    op(16, 19, 3, 0, 1);
    chk(OFS_FLAGS, 32'h0);
    for (int s = 0; s < 8; s++)
    begin
      wr(OFS_FLAGS, 32'h0);
      op(18, 0, s, 0, 1);
      chk(OFS_FLAGS, 32'h1 << s);
      wr(OFS_FLAGS, 32'hff);
      op(19, 0, s, 0, 1);
      chk(OFS_FLAGS, 32'hff ^ (32'h1 << s));
    end
    wr(OFS_FLAGS, 32'h5a);
    op(20, 0, 0, 0, 1);
    op(21, 0, 0, 0, 1);
    op(22, 0, 0, 0, 1);
    dbg_en <= 1'b1;
    op(22, 0, 0, 0, 1);
    chk(OFS_FLAGS, 32'h5a);
    end_sim;
  end
endmodule
